// ---- core/pvic_pkg.sv ----
// Function
// - seventeen sources: eight external, eight internal, one software break
// - maskable interrupt needs request 1, enable 1 and disable flag 0
// - software writes set and clear every enable bit
// - software may clear request bits, only hardware events set them
// - break is taken regardless of disable flag and enable bits
// - among simultaneous qualified requests the highest fixed priority wins
// - acceptance first pushes program counter and status onto the stack
// - then disable flag is set and accepted request bit cleared
// - finally the program counter loads the accepted source's vector
// - fixed order reset, ext a, ext b, rx, tx, timers x y 2 3, counter pins, timer 1, ext c, ext d, keys, trigger/conversion, break
// - vectors are low/high byte pairs from FFFC down two per priority step
// - reset acts as top-priority non-maskable interrupt using the top vector
// - external and counter pins set requests on edges of selectable polarity
// - receive request set on word completion, serial requests need serial mode
// - transmit request on shift completion or on buffer empty
// - each of five timers sets its own request on underflow
// - key request on falling edge of AND of input-mode key pins
// - priority 16 shared by trigger falling edge or conversion done, as selected
// - changing edge selection may set the related request spuriously
// - switching the shared source may set its request spuriously
// - disable flag is status bit 2, value 1 masks
// - stacked status of a break carries break flag 1
// - key request arises from a falling edge on an input-mode key pin while all other input-mode key pins are high
package pvic_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_REQ     = 8'h00;
	localparam logic [7:0]  REG_EN      = 8'h04;
	localparam logic [7:0]  REG_EDGE    = 8'h08;
	localparam logic [7:0]  REG_CFG     = 8'h0C;
	localparam logic [7:0]  REG_STAT    = 8'h10;
	localparam logic [15:0] RST_REQ     = 16'h0000;
	localparam logic [15:0] RST_EN      = 16'h0000;
	localparam logic [5:0]  RST_EDGE    = 6'h00;
	localparam logic [1:0]  RST_CFG     = 2'h0;
	// cfg field positions
	localparam int          CFG_CONV_ADC = 0;
	localparam int          CFG_TX_EMPTY = 1;
	// source indices, bit = priority - 2
	localparam int          NSRC        = 15;
	localparam logic [3:0]  IDX_BRK     = 4'hF;
	// status bits
	localparam int          PS_IFLAG    = 2;
	localparam int          PS_BRK      = 4;
	localparam logic [15:0] VEC_RESET   = 16'hFFFC;
	localparam logic [15:0] VEC_STEP    = 16'h0002;

	typedef enum logic [2:0] {ST_RESET, ST_IDLE, ST_PUSH, ST_MASK, ST_LOAD} pvic_state_e;

	// from the core
	typedef struct packed {
		logic       insn_boundary;
		logic       brk_exec;
		logic [7:0] status;
	} pvic_core_in_s;

	// to the core
	typedef struct packed {
		logic        accept;
		logic        push;
		logic [7:0]  push_status;
		logic        set_iflag;
		logic        load_pc;
		logic [15:0] vector;
	} pvic_core_out_s;

	// internal peripheral events, same clock
	typedef struct packed {
		logic rx_done;
		logic tx_shift_done;
		logic tx_empty;
		logic serial_sel;
		logic tmr_x;
		logic tmr_y;
		logic tmr_1;
		logic tmr_2;
		logic tmr_3;
		logic adc_done;
	} pvic_periph_s;
endpackage : pvic_pkg

// ---- core/pvic_ctrl.sv ----
`timescale 1ns/1ps
module pvic_ctrl (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    ce,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// pins
	input  wire logic                    ext_irq_a,
	input  wire logic                    ext_irq_b,
	input  wire logic                    ext_irq_c,
	input  wire logic                    ext_irq_d,
	input  wire logic                    counter_pin_a,
	input  wire logic                    counter_pin_b,
	input  wire logic                    conv_trigger_input,
	input  wire logic [7:0]              key_port,
	input  wire logic [7:0]              key_port_dir,
	// peripherals and core
	input  wire pvic_pkg::pvic_periph_s  periph,
	input  wire pvic_pkg::pvic_core_in_s core_in,
	output pvic_pkg::pvic_core_out_s     core_out
);
	import pvic_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0]    req_q;
	logic [15:0]    en_q;
	logic [5:0]     edge_q;
	logic [1:0]     cfg_q;
	logic           brk_pend_q;
	logic [3:0]     cur_q;
	pvic_state_e    st_q;
	pvic_core_out_s ack_q;
	logic [31:0]    prdata_q;
	logic           pready_q;
	logic           pslverr_q;
	logic [15:0]    sync1_q;
	logic [15:0]    sync2_q;
	logic [5:0]     lvl_prev_q;
	logic           key_prev_q;
	logic           conv_prev_q;

	logic [5:0]     pin_s;
	logic [5:0]     lvl;
	logic [5:0]     pin_ev;
	logic           key_and;
	logic           conv_lvl;
	logic [15:0]    ev;
	logic [15:0]    qual;
	logic [3:0]     win;
	logic           iflag;
	logic           take;
	logic           brk_sel;
	logic           wr;
	logic           rd_setup;
	logic [15:0]    sw_clr;

	assign iflag = core_in.status[PS_IFLAG];

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// two flops per pin, reset to idle high so no false edge follows reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 16'hFFFF;
			sync2_q <= 16'hFFFF;
		end else if (ce) begin
			sync1_q <= {conv_trigger_input, counter_pin_b, counter_pin_a, ext_irq_d,
				ext_irq_c, ext_irq_b, ext_irq_a, 1'b0, key_port};
			sync2_q <= sync1_q;
		end
	end

	assign pin_s = sync2_q[14:9];

	// ------------------------------------------------------------
	// event detection
	// ------------------------------------------------------------
	// polarity bit 1 picks rising edge, 0 falling
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_edge
			assign lvl[gi]    = edge_q[gi] ? pin_s[gi] : ~pin_s[gi];
			assign pin_ev[gi] = lvl[gi] & ~lvl_prev_q[gi];
		end
	endgenerate

	// output-mode key pins count as high in the conjunction
	assign key_and  = &(sync2_q[7:0] | key_port_dir);
	// shared source level, a source switch may look like an event
	assign conv_lvl = cfg_q[CFG_CONV_ADC] ? periph.adc_done : ~sync2_q[15];

	// event vector, bit = priority - 2
	always_comb begin
		ev     = 16'h0000;
		ev[0]  = pin_ev[0];
		ev[1]  = pin_ev[1];
		ev[2]  = periph.serial_sel & periph.rx_done;
		ev[3]  = periph.serial_sel & (cfg_q[CFG_TX_EMPTY] ? periph.tx_empty
			: periph.tx_shift_done);
		ev[4]  = periph.tmr_x;
		ev[5]  = periph.tmr_y;
		ev[6]  = periph.tmr_2;
		ev[7]  = periph.tmr_3;
		ev[8]  = pin_ev[4];
		ev[9]  = pin_ev[5];
		ev[10] = periph.tmr_1;
		ev[11] = pin_ev[2];
		ev[12] = pin_ev[3];
		ev[13] = key_prev_q & ~key_and;
		ev[14] = conv_lvl & ~conv_prev_q;
	end

	// previous levels for edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lvl_prev_q  <= 6'h00;
			key_prev_q  <= 1'b1;
			conv_prev_q <= 1'b0;
		end else if (ce) begin
			lvl_prev_q  <= lvl;
			key_prev_q  <= key_and;
			conv_prev_q <= conv_lvl;
		end
	end

	// ------------------------------------------------------------
	// qualification and priority
	// ------------------------------------------------------------
	assign qual = req_q & en_q & {16{~iflag}};

	// lowest set index is the highest priority
	always_comb begin
		win = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (qual[i]) begin
				win = 4'(i);
			end
		end
	end

	// break only when no maskable source is qualified
	assign brk_sel = (qual == 16'h0000) & brk_pend_q;
	assign take    = (st_q == ST_IDLE) & core_in.insn_boundary
		& ((qual != 16'h0000) | brk_pend_q);

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	assign wr       = psel & penable & pready_q & pwrite;
	assign rd_setup = psel & ~penable;
	assign sw_clr   = (wr && paddr == REG_REQ) ? ~pwdata[15:0] : 16'h0000;

	// no wait state, answer registered in the setup phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q  <= rd_setup;
			pslverr_q <= rd_setup & ~(paddr == REG_REQ || paddr == REG_EN
				|| paddr == REG_EDGE || paddr == REG_CFG || paddr == REG_STAT);
			if (rd_setup && !pwrite) begin
				case (paddr)
					REG_REQ:  prdata_q <= {16'h0000, req_q};
					REG_EN:   prdata_q <= {16'h0000, en_q};
					REG_EDGE: prdata_q <= {26'h0000000, edge_q};
					REG_CFG:  prdata_q <= {30'h00000000, cfg_q};
					REG_STAT: prdata_q <= {24'h000000, brk_pend_q, st_q, cur_q};
					default:  prdata_q <= 32'h0000_0000;
				endcase
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// control registers written by software
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_q   <= RST_EN;
			edge_q <= RST_EDGE;
			cfg_q  <= RST_CFG;
		end else if (ce && wr) begin
			case (paddr)
				REG_EN:   en_q   <= {1'b0, pwdata[14:0]};
				REG_EDGE: edge_q <= pwdata[5:0];
				REG_CFG:  cfg_q  <= pwdata[1:0];
				default:  ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// request bits
	// ------------------------------------------------------------
	// write of 0 clears, 1 keeps; an event in the same cycle wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_q <= RST_REQ;
		end else if (ce) begin
			for (int i = 0; i < NSRC; i++) begin
				if (ev[i]) begin
					req_q[i] <= 1'b1;
				end else if (sw_clr[i] || (st_q == ST_MASK && cur_q == 4'(i))) begin
					req_q[i] <= 1'b0;
				end
			end
		end
	end

	// break pending until its acceptance
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			brk_pend_q <= 1'b0;
		end else if (ce) begin
			if (core_in.brk_exec) begin
				brk_pend_q <= 1'b1;
			end else if (st_q == ST_MASK && cur_q == IDX_BRK) begin
				brk_pend_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// acceptance sequence
	// ------------------------------------------------------------
	// reset fetch, then push, mask, load per accepted interrupt
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q  <= ST_RESET;
			cur_q <= 4'h0;
			ack_q <= '0;
		end else if (ce) begin
			ack_q.accept    <= 1'b0;
			ack_q.push      <= 1'b0;
			ack_q.set_iflag <= 1'b0;
			ack_q.load_pc   <= 1'b0;
			case (st_q)
				ST_RESET: begin
					ack_q.vector  <= VEC_RESET;
					ack_q.load_pc <= 1'b1;
					st_q          <= ST_IDLE;
				end
				ST_IDLE: begin
					if (take) begin
						cur_q              <= brk_sel ? IDX_BRK : win;
						ack_q.accept       <= 1'b1;
						ack_q.push         <= 1'b1;
						ack_q.push_status  <= core_in.status;
						ack_q.push_status[PS_BRK] <= brk_sel;
						ack_q.vector       <= VEC_RESET - VEC_STEP
							- {11'h000, brk_sel ? IDX_BRK : win, 1'b0};
						st_q               <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					ack_q.set_iflag <= 1'b1;
					st_q            <= ST_MASK;
				end
				ST_MASK: begin
					ack_q.load_pc <= 1'b1;
					st_q          <= ST_LOAD;
				end
				ST_LOAD: begin
					st_q <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign core_out = ack_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_take;
		ce && take;
	endsequence

	sequence s_two_ce;
		ce [*2];
	endsequence

	req_only_hw_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && ev == 16'h0000 |=> (req_q & ~$past(req_q)) == 16'h0000)
		else $error("request bit set without event");

	mask_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		s_take and !brk_sel |-> !iflag && (req_q & en_q) != 16'h0000)
		else $error("masked source taken");

	brk_unmask_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && st_q == ST_IDLE && core_in.insn_boundary && brk_pend_q && qual == 16'h0000
		|=> ack_q.push && cur_q == IDX_BRK)
		else $error("break not taken");

	prio_win_a: assert property (@(posedge clk) disable iff (!resetn)
		s_take and !brk_sel |-> (qual & ((16'h0001 << win) - 16'h0001)) == 16'h0000
		&& qual[win])
		else $error("lower priority granted");

	accept_chain_a: assert property (@(posedge clk) disable iff (!resetn)
		s_take ##1 s_two_ce |-> ack_q.set_iflag && $past(ack_q.push)
		##0 !ack_q.push)
		else $error("push before mask order broken");

	req_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && st_q == ST_MASK && cur_q != IDX_BRK && !ev[cur_q]
		|=> !req_q[$past(cur_q)] && ack_q.load_pc)
		else $error("accepted request not cleared");

	vec_addr_a: assert property (@(posedge clk) disable iff (!resetn)
		ack_q.push |-> ack_q.vector == 16'hFFFA - {11'h000, cur_q, 1'b0})
		else $error("wrong vector address");

	reset_vec_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && resetn && st_q == ST_RESET |=> ack_q.load_pc && ack_q.vector == 16'hFFFC)
		else $error("reset vector not loaded");

	brk_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		ack_q.push |-> ack_q.push_status[PS_BRK] == (cur_q == IDX_BRK))
		else $error("stacked break flag wrong");

	// event capture per source
	edge_set_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && pin_ev != 6'h00
		|=> ($past(pin_ev) & ~{req_q[9:8], req_q[12:11], req_q[1:0]}) == 6'h00)
		else $error("pin edge not captured");

	serial_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && !periph.serial_sel && req_q[3:2] == 2'h0 |=> req_q[3:2] == 2'h0)
		else $error("serial request without serial mode");

	tx_source_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && periph.serial_sel && cfg_q[CFG_TX_EMPTY] && periph.tx_empty |=> req_q[3])
		else $error("buffer empty not captured");

	timer_set_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && periph.tmr_x |=> req_q[4])
		else $error("timer underflow not captured");

	key_set_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && key_prev_q && !key_and |=> req_q[13])
		else $error("key fall not captured");

	conv_set_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && cfg_q[CFG_CONV_ADC] && periph.adc_done && !conv_prev_q |=> req_q[14])
		else $error("conversion done not captured");

	req_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && st_q != ST_MASK && sw_clr == 16'h0000 |=> (req_q & $past(req_q)) == $past(req_q))
		else $error("request bit lost");
endmodule : pvic_ctrl

// ---- verification/pvic_core_model.sv ----
`timescale 1ns/1ps
module pvic_core_model (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     resetn,
	// bench controls
	input  wire logic                     brk_req,
	input  wire logic                     iflag_clr,
	input  wire logic                     slow,
	// controller side
	input  wire pvic_pkg::pvic_core_out_s core_out,
	output pvic_pkg::pvic_core_in_s       core_in
);
	import pvic_pkg::*;
	logic [1:0] up_q;
	logic [1:0] cnt_q;
	logic       iflag_q;
	// ------------------------------------------------------------
	// pacing and disable flag
	// ------------------------------------------------------------
	// boundaries only from the second edge after reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) up_q <= 2'h0;
		else if (!up_q[1]) up_q <= up_q + 2'h1;
	end
	// slow mode offers a boundary every fourth cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) cnt_q <= 2'h0;
		else cnt_q <= cnt_q + 2'h1;
	end
	// flag raised after acceptance, lowered by handler return
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) iflag_q <= 1'h1;
		else if (core_out.set_iflag) iflag_q <= 1'h1;
		else if (iflag_clr) iflag_q <= 1'h0;
	end
	assign core_in.insn_boundary = up_q[1] && (!slow || cnt_q == 2'h0);
	assign core_in.brk_exec      = brk_req;
	// live break flag always 0, disable flag at bit 2
	assign core_in.status        = {5'h00, iflag_q, 2'h0};
endmodule : pvic_core_model

// ---- verification/pvic_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module pvic_ctrl_tb_top;
	import pvic_pkg::*;
	logic clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00, key_port = 8'hFF, key_dir = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000862A, rnd;
	logic pready, pslverr, brk_req = 1'h0, iflag_clr = 1'h0, slow = 1'h0;
	logic [6:0] pin = 7'h7F;
	pvic_periph_s periph = '0;
	pvic_core_in_s core_in;
	pvic_core_out_s core_out;
	logic [32:0] exp_rd[$], exp_vec[$], e;
	int n_mismatch = 0, num_checks = 0, i;
	int idx[7] = '{2, 3, 4, 5, 6, 7, 10};
	// ------------------------------------------------------------
	// clock, design and core model
	// ------------------------------------------------------------
	always #12.5 clk = ~clk;
	pvic_ctrl uut (.clk(clk), .resetn(resetn), .ce(1'h1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_irq_a(pin[0]), .ext_irq_b(pin[1]), .ext_irq_c(pin[2]),
		.ext_irq_d(pin[3]), .counter_pin_a(pin[4]), .counter_pin_b(pin[5]),
		.conv_trigger_input(pin[6]), .key_port(key_port), .key_port_dir(key_dir),
		.periph(periph), .core_in(core_in), .core_out(core_out));
	pvic_core_model core (.clk(clk), .resetn(resetn), .brk_req(brk_req),
		.iflag_clr(iflag_clr), .slow(slow), .core_out(core_out), .core_in(core_in));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] sn);
		num_checks++;
		if (sn !== ex) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	// one apb transfer, held until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] ex = 33'h0);
		int n;
		if (!w) exp_rd.push_back(ex);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
		if (n >= 20) begin
			n_mismatch++;
			end_of_test();
		end
	endtask : apb
	// wait for a vector load under a bound
	task automatic wait_load();
		int n;
		for (n = 0; n < 60 && core_out.load_pc !== 1'h1; n++) @(posedge clk);
		if (n >= 60) begin
			n_mismatch++;
			end_of_test();
		end
		@(posedge clk);
	endtask : wait_load
	// ------------------------------------------------------------
	// monitor: oldest note against each answer
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			e = exp_rd.size() ? exp_rd.pop_front() : 33'h1FFFFFFFF;
			chk("read", e, {pslverr, prdata});
		end
		if (core_out.load_pc === 1'h1) begin
			e = exp_vec.size() ? exp_vec.pop_front() : 33'h1FFFFFFFF;
			chk("vector", e, {16'h0, core_out.push_status[PS_BRK], core_out.vector});
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		exp_vec.push_back({17'h0, VEC_RESET});
		repeat (12) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		// reset values, unmapped place
		apb(0, REG_REQ, 0, 33'h0);
		apb(0, REG_EN, 0, 33'h0);
		apb(0, REG_EDGE, 0, 33'h0);
		apb(0, REG_CFG, 0, 33'h0);
		apb(0, 8'h14, 0, 33'h100000000);
		rnd = xs(seed);
		apb(1, REG_EN, rnd, 0);
		apb(0, REG_EN, 0, {18'h0, rnd[14:0]});
		apb(1, REG_EN, 0, 0);
		apb(1, REG_REQ, 32'hFFFFFFFF, 0);
		apb(0, REG_REQ, 0, 33'h0);
		// random edge polarity, then clear any spurious set
		rnd = xs(rnd);
		apb(1, REG_EDGE, {26'h0, rnd[5:0]}, 0);
		repeat (5) @(posedge clk);
		apb(1, REG_REQ, 0, 0);
		key_dir <= rnd[15:8] & ~(8'h01 << rnd[18:16]);
		pin <= 7'h00;
		key_port[rnd[18:16]] <= 1'h0;
		repeat (5) @(posedge clk);
		apb(0, REG_REQ, 0, {17'h0, 3'h3, ~rnd[3:2], 1'h0, ~rnd[5:4], 6'h0, ~rnd[1:0]});
		apb(1, REG_REQ, 0, 0);
		pin <= 7'h7F;
		key_port <= 8'hFF;
		repeat (5) @(posedge clk);
		apb(0, REG_REQ, 0, {17'h0, 3'h0, rnd[3:2], 1'h0, rnd[5:4], 6'h0, rnd[1:0]});
		apb(1, REG_REQ, 0, 0);
		// serial receive ignored while serial function is off
		periph.rx_done <= 1'h1;
		@(posedge clk);
		periph.rx_done <= 1'h0;
		periph.serial_sel <= 1'h1;
		repeat (2) @(posedge clk);
		apb(0, REG_REQ, 0, 33'h0);
		// alternate sources: buffer empty and conversion done
		apb(1, REG_CFG, 32'h00000003, 0);
		repeat (2) @(posedge clk);
		apb(1, REG_REQ, 0, 0);
		{periph.tx_empty, periph.adc_done} <= 2'h3;
		@(posedge clk);
		{periph.tx_empty, periph.adc_done} <= 2'h0;
		repeat (2) @(posedge clk);
		apb(0, REG_REQ, 0, 33'h000004008);
		apb(1, REG_REQ, 0, 0);
		apb(1, REG_CFG, 0, 0);
		{periph.rx_done, periph.tx_shift_done, periph.tmr_x, periph.tmr_y, periph.tmr_1,
			periph.tmr_2, periph.tmr_3} <= 7'h7F;
		@(posedge clk);
		{periph.rx_done, periph.tx_shift_done, periph.tmr_x, periph.tmr_y, periph.tmr_1,
			periph.tmr_2, periph.tmr_3} <= 7'h00;
		repeat (2) @(posedge clk);
		apb(0, REG_REQ, 0, 33'h000004FC);
		apb(1, REG_EN, 32'h00007FFF, 0);
		// drain by priority, one handler return at a time
		for (i = 0; i < 7; i++) begin
			exp_vec.push_back({17'h0, VEC_RESET - VEC_STEP * 16'(idx[i] + 1)});
			slow <= i[0];
			iflag_clr <= 1'h1;
			@(posedge clk);
			iflag_clr <= 1'h0;
			wait_load();
		end
		slow <= 1'h0;
		apb(0, REG_REQ, 0, 33'h0);
		// break taken while the disable flag is set
		exp_vec.push_back({16'h0, 1'h1, VEC_RESET - VEC_STEP * 16'h10});
		brk_req <= 1'h1;
		@(posedge clk);
		brk_req <= 1'h0;
		wait_load();
		repeat (4) @(posedge clk);
		chk("notes left", 33'h0, 33'(exp_rd.size() + exp_vec.size()));
		end_of_test();
	end
endmodule : pvic_ctrl_tb_top
